// ==== rtl/hsc_pkg.sv ====
// Constants shared by the heat-sealing control sequencer.
package hsc_pkg;
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned FLASH_HZ = 4;
   localparam int unsigned FLASH_CYC = CLK_HZ / (2 * FLASH_HZ);
   localparam int unsigned PON_S = 10;
   localparam int unsigned PON_CYC = 32'(64'(PON_S) * 64'(CLK_HZ));
   localparam int unsigned CAL_S = 12;
   localparam int unsigned CAL_CYC = 32'(64'(CAL_S) * 64'(CLK_HZ));
   localparam int unsigned REINIT_MS = 500;
   localparam int unsigned REINIT_CYC = 32'(64'(REINIT_MS) * 64'(CLK_HZ) / 64'd1000);
   localparam int unsigned DEB_MS = 1;
   localparam int unsigned DEB_CYC = 32'(64'(DEB_MS) * 64'(CLK_HZ) / 64'd1000);
   localparam int unsigned ADC_MAX = 1023;
   localparam int unsigned FS_LO_C = 300;
   localparam int unsigned FS_HI_C = 500;
   localparam int unsigned SP_MIN_C = 40;
   localparam int unsigned CAL_REF_C = 20;
   localparam int unsigned EXT_REF_MAX_C = 40;
   localparam int unsigned CP_MIN_PCT = 5;
   localparam int unsigned TOK_PCT = 95;
   localparam int unsigned COOL_MAX_MKS = 100;
   localparam int unsigned CAL_TRIES = 3;
   localparam int unsigned ERR_CAL_FAIL = 114;
   localparam int unsigned ERR_REF_HIGH = 115;
   localparam int unsigned ERR_REF_FLUCT = 116;
   localparam int unsigned ERR_PWR_LO = 101;
   localparam int unsigned ERR_PWR_HI = 103;
   localparam int unsigned ERR_MEAS_LO = 201;
   localparam int unsigned ERR_MEAS_HI = 203;
   localparam int unsigned ERR_SYS_LO = 900;
   localparam int unsigned ERR_SYS_HI = 999;
   localparam int unsigned PIN_CAL = 0;
   localparam int unsigned PIN_START = 1;
   localparam int unsigned PIN_RESET = 2;
   localparam int unsigned PIN_CP = 3;
   localparam int unsigned PIN_N = 4;
endpackage

// ==== rtl/hsc_pin_if.sv ====
// Interface between a control-pin conditioner and the sequencer.
`timescale 1ns/100ps
interface hsc_pin_if;
   logic raw;
   logic lvl;
   modport deb (input raw, output lvl);
   modport top (output raw, input lvl);
endinterface

// ==== rtl/hsc_debounce.sv ====
// Synchroniser and debouncer for one 24 V control input.
`timescale 1ns/100ps
module hsc_debounce #(
   parameter int unsigned DEB_CYC = hsc_pkg::DEB_CYC
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Pin in, clean level out.
   hsc_pin_if.deb p
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      logic [31:0] cnt;
   } hsc_deb_t;

   hsc_deb_t q_q;
   hsc_deb_t q_d;

   always_comb begin
      q_d = q_q;
      q_d.s1 = p.raw;
      q_d.s2 = q_q.s1;
      q_d.s3 = q_q.s2;
      // A change is counted only while the second and third stage agree.
      if (q_q.s2 == q_q.s3 && q_q.s3 != q_q.lvl) begin
         if (q_q.cnt == 32'(DEB_CYC - 1)) begin
            q_d.lvl = q_q.s3;
            q_d.cnt = '0;
         end else begin
            q_d.cnt = q_q.cnt + 32'h1;
         end
      end else begin
         q_d.cnt = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_q <= '0;
      end else begin
         q_q <= q_d;
      end
   end

   assign p.lvl = q_q.lvl;

   chk_deb_settle: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(q_q.lvl) |-> $past(q_q.cnt) == 32'(DEB_CYC - 1))
      else $error("Debounced level changed before the hold time.");
endmodule // hsc_debounce

// ==== rtl/hsc_sequencer.sv ====
// Control sequencer and indicators of the heat-sealing temperature controller.
// Overview of operation
// - Calibration LED flashes 4 Hz while calibration is requested but blocked.
// - Calibration LED stays on while a calibration run executes.
// - Heat LED stays on while a heating request is executed.
// - Constant-power LED on while running, flashes fast while requested but blocked.
// - Temperature-ok LED on inside monitoring band, or at 95% of setpoint.
// - Green output LED brightness follows heating current during control.
// - Setpoint input maps 0 V to 0 C, full scale 300 or 500 C.
// - Start with setpoint at or below 40 C gives no heating, heat LED flashes.
// - Actual-value output scales 0 C to zero and full scale to maximum.
// - Outside calibration and reset, the actual-value output carries the error indication during alarm.
// - Calibration reference defaults to 20 C.
// - External reference comes from setpoint input, 3 to 40 C, held by partner.
// - External reference above 40 C or fluctuating raises errors 115, 116.
// - A pulse starts calibration; it runs about 12 s without heating.
// - Actual-value output forced to zero during calibration.
// - Fluctuation retries calibration, three attempts total, then error 114.
// - Calibration requests within 10 s of power-on are rejected.
// - Calibration deferred while cooling above 0.1 K/s, starts when slower if the request is still held.
// - Calibration refused while start or reset asserted; calibration LED flashes.
// - Error groups block calibration; power errors only before first good run.
// - Heating regulates toward setpoint while start asserted, stops on release.
// - Start ignored during calibration or reset.
// - After reset release, 500 ms initialisation before next heating start.
`timescale 1ns/100ps
module hsc_sequencer #(
   parameter int unsigned PON_CYC = hsc_pkg::PON_CYC,
   parameter int unsigned CAL_CYC = hsc_pkg::CAL_CYC,
   parameter int unsigned REINIT_CYC = hsc_pkg::REINIT_CYC,
   parameter int unsigned FLASH_CYC = hsc_pkg::FLASH_CYC,
   parameter int unsigned DEB_CYC = hsc_pkg::DEB_CYC
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // 24 V control inputs.
   input wire logic zero_calibration_i,
   input wire logic start_req_i,
   input wire logic reset_req_i,
   input wire logic constant_power_request_i,
   // Configuration.
   input wire logic range_500_i,
   input wire logic ext_ref_sel_i,
   input wire logic band_mode_i,
   // Measurement and diagnosis.
   input wire logic [9:0] setpoint_code_i,
   input wire logic [9:0] actual_temp_i,
   input wire logic [7:0] heat_current_i,
   input wire logic [15:0] cool_rate_i,
   input wire logic temp_fluct_i,
   input wire logic ref_fluct_i,
   input wire logic band_ok_i,
   input wire logic err_valid_i,
   input wire logic [9:0] err_code_i,
   input wire logic alarm_i,
   input wire logic [9:0] alarm_level_i,
   // Indicators.
   output logic cal_led_o,
   output logic heat_led_o,
   output logic cp_led_o,
   output logic temp_ok_led_o,
   output logic output_led_o,
   // Control and status.
   output logic heat_enable_o,
   output logic cp_enable_o,
   output logic cal_busy_o,
   output logic [5:0] cal_ref_o,
   output logic [9:0] actual_out_o,
   output logic [9:0] cal_err_o,
   output logic cal_err_stb_o
);
   typedef enum logic [1:0] {CS_IDLE, CS_DEFER, CS_RUN} hsc_cs_t;
   typedef struct packed {
      hsc_cs_t cs;
      logic zc_prev;
      logic rs_prev;
      logic pon;
      logic [31:0] pcnt;
      logic [31:0] ccnt;
      logic [1:0] tries;
      logic fluct;
      logic okonce;
      logic [31:0] rcnt;
      logic [31:0] fcnt;
      logic [2:0] fdiv;
      logic [7:0] pwm;
      logic cal_led;
      logic heat_led;
      logic cp_led;
      logic tok_led;
      logic out_led;
      logic heat_en;
      logic cp_en;
      logic cal_busy;
      logic [5:0] ref_c;
      logic [9:0] act;
      logic [9:0] err;
      logic err_stb;
   } hsc_st_t;

   hsc_st_t st_q;
   hsc_st_t st_d;
   logic [hsc_pkg::PIN_N-1:0] raw_v;
   logic [hsc_pkg::PIN_N-1:0] lvl_v;
   logic zc, st, rs, cp;
   logic [9:0] fs_c, sp_c;
   logic [19:0] sp_prod, dac_prod, dac_q;
   logic [9:0] dac;
   logic eb, hard, cool_fast, go, run, hblk, cpblk, cal_req, fast, slow;

   assign raw_v[hsc_pkg::PIN_CAL] = zero_calibration_i;
   assign raw_v[hsc_pkg::PIN_START] = start_req_i;
   assign raw_v[hsc_pkg::PIN_RESET] = reset_req_i;
   assign raw_v[hsc_pkg::PIN_CP] = constant_power_request_i;

   for (genvar g = 0; g < hsc_pkg::PIN_N; g++) begin : g_pin
      hsc_pin_if pin ();
      assign pin.raw = raw_v[g];
      assign lvl_v[g] = pin.lvl;
      hsc_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .p(pin.deb)
      );
   end

   assign zc = lvl_v[hsc_pkg::PIN_CAL];
   assign st = lvl_v[hsc_pkg::PIN_START];
   assign rs = lvl_v[hsc_pkg::PIN_RESET];
   assign cp = lvl_v[hsc_pkg::PIN_CP];

   always_comb begin
      st_d = st_q;
      fs_c = range_500_i ? 10'(hsc_pkg::FS_HI_C) : 10'(hsc_pkg::FS_LO_C);
      sp_prod = 20'(setpoint_code_i) * 20'(fs_c);
      sp_c = 10'(sp_prod / 20'(hsc_pkg::ADC_MAX));
      dac_prod = 20'(actual_temp_i) * 20'(hsc_pkg::ADC_MAX);
      dac_q = dac_prod / 20'(fs_c);
      dac = (dac_q > 20'(hsc_pkg::ADC_MAX)) ? 10'(hsc_pkg::ADC_MAX) : dac_q[9:0];
      run = (st_q.cs == CS_RUN);
      fast = st_q.fdiv[0];
      slow = st_q.fdiv[2];
      // Blocking error groups; power-side errors count only before the first good run.
      eb = err_valid_i && ((err_code_i >= 10'(hsc_pkg::ERR_MEAS_LO) && err_code_i <= 10'(hsc_pkg::ERR_MEAS_HI))
         || (err_code_i >= 10'(hsc_pkg::ERR_SYS_LO) && err_code_i <= 10'(hsc_pkg::ERR_SYS_HI))
         || (!st_q.okonce && err_code_i >= 10'(hsc_pkg::ERR_PWR_LO)
         && err_code_i <= 10'(hsc_pkg::ERR_PWR_HI)));
      hard = !st_q.pon || st || rs || eb;
      cool_fast = cool_rate_i > 16'(hsc_pkg::COOL_MAX_MKS);
      go = 1'b0;
      st_d.err_stb = 1'b0;
      st_d.zc_prev = zc;
      st_d.rs_prev = rs;

      if (!st_q.pon) begin
         if (st_q.pcnt == 32'(PON_CYC - 1)) begin
            st_d.pon = 1'b1;
         end else begin
            st_d.pcnt = st_q.pcnt + 32'h1;
         end
      end

      if (st_q.fcnt == 32'(FLASH_CYC - 1)) begin
         st_d.fcnt = '0;
         st_d.fdiv = st_q.fdiv + 3'h1;
      end else begin
         st_d.fcnt = st_q.fcnt + 32'h1;
      end

      if (st_q.rs_prev && !rs) begin
         st_d.rcnt = 32'(REINIT_CYC);
      end else if (st_q.rcnt != 32'h0) begin
         st_d.rcnt = st_q.rcnt - 32'h1;
      end

      case (st_q.cs)
         CS_IDLE: begin
            // The request is a pulse; a rejected one is dropped, not remembered.
            if (zc && !st_q.zc_prev && !hard) begin
               st_d.tries = '0;
               if (cool_fast) begin
                  st_d.cs = CS_DEFER;
               end else begin
                  go = 1'b1;
               end
            end
         end
         CS_DEFER: begin
            if (!zc || hard) begin
               st_d.cs = CS_IDLE;
            end else if (!cool_fast) begin
               go = 1'b1;
            end
         end
         CS_RUN: begin
            st_d.ccnt = st_q.ccnt + 32'h1;
            if (temp_fluct_i) begin
               st_d.fluct = 1'b1;
            end
            if (ext_ref_sel_i && ref_fluct_i) begin
               st_d.cs = CS_IDLE;
               st_d.err = 10'(hsc_pkg::ERR_REF_FLUCT);
               st_d.err_stb = 1'b1;
            end else if (st_q.ccnt == 32'(CAL_CYC - 1)) begin
               if (st_q.fluct || temp_fluct_i) begin
                  if (st_q.tries == 2'(hsc_pkg::CAL_TRIES - 1)) begin
                     st_d.cs = CS_IDLE;
                     st_d.err = 10'(hsc_pkg::ERR_CAL_FAIL);
                     st_d.err_stb = 1'b1;
                  end else begin
                     st_d.tries = st_q.tries + 2'h1;
                     st_d.ccnt = '0;
                     st_d.fluct = 1'b0;
                  end
               end else begin
                  st_d.cs = CS_IDLE;
                  st_d.okonce = 1'b1;
               end
            end
         end
         default: begin
            st_d.cs = CS_IDLE;
         end
      endcase

      if (go) begin
         if (ext_ref_sel_i && sp_c > 10'(hsc_pkg::EXT_REF_MAX_C)) begin
            st_d.cs = CS_IDLE;
            st_d.err = 10'(hsc_pkg::ERR_REF_HIGH);
            st_d.err_stb = 1'b1;
         end else begin
            st_d.cs = CS_RUN;
            st_d.ccnt = '0;
            st_d.fluct = 1'b0;
            st_d.err = '0;
            st_d.ref_c = ext_ref_sel_i ? sp_c[5:0] : 6'(hsc_pkg::CAL_REF_C);
         end
      end

      st_d.cal_busy = (st_d.cs == CS_RUN);
      cal_req = zc || (st_q.cs == CS_DEFER);
      if (run) begin
         st_d.cal_led = 1'b1;
      end else if (cal_req && (hard || st_q.cs == CS_DEFER)) begin
         st_d.cal_led = fast;
      end else begin
         st_d.cal_led = rs && slow;
      end

      // The cycle right after reset is released still blocks, before the reinit counter is loaded.
      hblk = run || rs || st_q.rs_prev || st_q.rcnt != 32'h0 || sp_c <= 10'(hsc_pkg::SP_MIN_C);
      st_d.heat_en = st && !hblk;
      if (st_q.heat_en) begin
         st_d.heat_led = 1'b1;
      end else begin
         st_d.heat_led = st && hblk && fast;
      end
      if (st_q.heat_en && !err_valid_i) begin
         st_d.okonce = 1'b1;
      end

      cpblk = run || rs || (17'(setpoint_code_i) * 17'd100
         <= 17'(hsc_pkg::ADC_MAX) * 17'(hsc_pkg::CP_MIN_PCT));
      st_d.cp_en = cp && !cpblk;
      st_d.cp_led = st_q.cp_en || (cp && cpblk && fast);

      if (band_mode_i) begin
         st_d.tok_led = band_ok_i;
      end else begin
         st_d.tok_led = 17'(actual_temp_i) * 17'd100 >= 17'(sp_c) * 17'(hsc_pkg::TOK_PCT);
      end

      st_d.pwm = st_q.pwm + 8'h1;
      st_d.out_led = st_q.heat_en && (st_q.pwm < heat_current_i);

      if (run || rs) begin
         st_d.act = '0;
      end else if (alarm_i) begin
         st_d.act = alarm_level_i;
      end else begin
         st_d.act = dac;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign cal_led_o = st_q.cal_led;
   assign heat_led_o = st_q.heat_led;
   assign cp_led_o = st_q.cp_led;
   assign temp_ok_led_o = st_q.tok_led;
   assign output_led_o = st_q.out_led;
   assign heat_enable_o = st_q.heat_en;
   assign cp_enable_o = st_q.cp_en;
   assign cal_busy_o = st_q.cal_busy;
   assign cal_ref_o = st_q.ref_c;
   assign actual_out_o = st_q.act;
   assign cal_err_o = st_q.err;
   assign cal_err_stb_o = st_q.err_stb;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_cal_led_run: assert property (cal_busy_o |=> cal_led_o)
      else $error("Calibration LED dark during a run.");
   chk_act_zero_cal: assert property (cal_busy_o |=> actual_out_o == 10'h0)
      else $error("Actual output not zero during calibration.");
   chk_heat_setpoint: assert property (heat_enable_o |-> $past(sp_c) > 10'(hsc_pkg::SP_MIN_C))
      else $error("Heating with setpoint at or below minimum.");
   chk_no_heat_cal: assert property (!(heat_enable_o && cal_busy_o))
      else $error("Heating and calibration at once.");
   chk_cal_after_pon: assert property ($rose(cal_busy_o) |-> st_q.pon && !$past(st) && !$past(rs))
      else $error("Calibration started while blocked.");
   chk_retry_cap: assert property (st_q.tries < 2'(hsc_pkg::CAL_TRIES))
      else $error("Calibration retry count exceeded.");
   chk_fail_code: assert property ((cal_err_stb_o && cal_err_o == 10'(hsc_pkg::ERR_CAL_FAIL))
      |-> $past(st_q.tries) == 2'(hsc_pkg::CAL_TRIES - 1))
      else $error("Calibration failure reported too early.");
   chk_flash_rate: assert property ($changed(st_q.fdiv) |-> $past(st_q.fcnt) == 32'(FLASH_CYC - 1))
      else $error("Flash divider stepped at the wrong count.");
   chk_reinit_hold: assert property (heat_enable_o |-> $past(st_q.rcnt) == 32'h0 && !$past(rs)
      && !$past(st_q.rs_prev))
      else $error("Heating started during reset initialisation.");
   chk_heat_led_on: assert property (heat_enable_o |=> heat_led_o)
      else $error("Heat LED dark while heating.");

   cov_cal_done: cover property (cal_busy_o ##1 !cal_busy_o && !cal_err_stb_o);
   cov_heating: cover property ($rose(heat_enable_o));
   cov_cal_fail: cover property (cal_err_stb_o && cal_err_o == 10'(hsc_pkg::ERR_CAL_FAIL));
endmodule // hsc_sequencer

// ==== test/hsc_plc_model.sv ====
// Behavioural model of the machine controller that drives the control pins.
`timescale 1ns/100ps
module hsc_plc_model (
   // Clock.
   input wire logic clk_i,
   // Control pins and setpoint.
   output logic zero_calibration_o,
   output logic start_req_o,
   output logic reset_req_o,
   output logic constant_power_request_o,
   output logic [9:0] setpoint_code_o
);
   initial begin
      zero_calibration_o = 1'b0;
      start_req_o = 1'b0;
      reset_req_o = 1'b0;
      constant_power_request_o = 1'b0;
      setpoint_code_o = 10'h000;
   end
   // Levels change just after a falling edge and then stay put.
   task automatic drive(input logic st, input logic rs, input logic cp, input logic [9:0] sp);
      @(negedge clk_i);
      start_req_o = st;
      reset_req_o = rs;
      constant_power_request_o = cp;
      setpoint_code_o = sp;
   endtask
   // The setpoint is left untouched for the whole pulse.
   task automatic cal(input int hold);
      @(negedge clk_i);
      zero_calibration_o = 1'b1;
      repeat (hold) @(negedge clk_i);
      zero_calibration_o = 1'b0;
      // The pin rests low until the debouncer has seen the release, so a next pulse is a fresh edge.
      repeat (8) @(negedge clk_i);
   endtask
endmodule // hsc_plc_model

// ==== test/test_heat_sealing_control_sequencer.sv ====
// Self-checking testbench of the heat-sealing control sequencer.
`timescale 1ns/100ps
module test_heat_sealing_control_sequencer;
   localparam int CAL_CYC = 50;
   logic clk_i, rst_i, zc, st, rs, cp, range_500_i, ext_ref_sel_i, band_mode_i;
   logic [9:0] sp, actual_temp_i, err_code_i, alarm_level_i;
   logic [7:0] heat_current_i;
   logic [15:0] cool_rate_i;
   logic temp_fluct_i, ref_fluct_i, band_ok_i, err_valid_i, alarm_i;
   logic cal_led_o, heat_led_o, cp_led_o, temp_ok_led_o, output_led_o;
   logic heat_enable_o, cp_enable_o, cal_busy_o, cal_err_stb_o;
   logic [5:0] cal_ref_o;
   logic [9:0] actual_out_o, cal_err_o;
   int err_total = 0;
   int checks_done = 0;
   int cyc_cnt = 0;
   int n;
   hsc_plc_model hsc_plc_model_i (.clk_i(clk_i), .zero_calibration_o(zc), .start_req_o(st), .reset_req_o(rs),
      .constant_power_request_o(cp), .setpoint_code_o(sp));
   hsc_sequencer #(.PON_CYC(200), .CAL_CYC(CAL_CYC), .REINIT_CYC(30), .FLASH_CYC(8), .DEB_CYC(4)) hsc_sequencer_i (
      .clk_i(clk_i), .rst_i(rst_i), .zero_calibration_i(zc), .start_req_i(st), .reset_req_i(rs),
      .constant_power_request_i(cp), .range_500_i(range_500_i), .ext_ref_sel_i(ext_ref_sel_i),
      .band_mode_i(band_mode_i), .setpoint_code_i(sp), .actual_temp_i(actual_temp_i),
      .heat_current_i(heat_current_i), .cool_rate_i(cool_rate_i), .temp_fluct_i(temp_fluct_i),
      .ref_fluct_i(ref_fluct_i), .band_ok_i(band_ok_i), .err_valid_i(err_valid_i), .err_code_i(err_code_i),
      .alarm_i(alarm_i), .alarm_level_i(alarm_level_i), .cal_led_o(cal_led_o), .heat_led_o(heat_led_o),
      .cp_led_o(cp_led_o), .temp_ok_led_o(temp_ok_led_o), .output_led_o(output_led_o),
      .heat_enable_o(heat_enable_o), .cp_enable_o(cp_enable_o), .cal_busy_o(cal_busy_o), .cal_ref_o(cal_ref_o),
      .actual_out_o(actual_out_o), .cal_err_o(cal_err_o), .cal_err_stb_o(cal_err_stb_o));
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   task automatic test_done;
      $display("mismatches %0d of %0d comparisons", err_total, checks_done);
      if (err_total == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         err_total++;
         test_done;
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   function automatic logic sg(input int s);
      case (s)
         0: sg = cal_busy_o;
         1: sg = heat_enable_o;
         2: sg = cal_err_stb_o;
         3: sg = cp_enable_o;
         4: sg = cal_led_o;
         5: sg = heat_led_o;
         6: sg = cp_led_o;
         default: sg = output_led_o;
      endcase
   endfunction
   task automatic cyc(input int k);
      repeat (k) @(negedge clk_i);
   endtask
   // Setters for the measurement, diagnosis and option inputs.
   task automatic set_meas(input logic [9:0] t, input logic [7:0] i, input logic [15:0] r);
      actual_temp_i = t;
      heat_current_i = i;
      cool_rate_i = r;
   endtask
   task automatic set_diag(input logic v, input logic [9:0] c, input logic a, input logic [9:0] l);
      err_valid_i = v;
      err_code_i = c;
      alarm_i = a;
      alarm_level_i = l;
   endtask
   task automatic set_flags(input logic e, input logic t, input logic r);
      ext_ref_sel_i = e;
      temp_fluct_i = t;
      ref_fluct_i = r;
   endtask
   // Counts the cycles in which the chosen output is high.
   task automatic cnt(input int s, input int k, output int c);
      c = 0;
      repeat (k) begin
         @(negedge clk_i);
         if (sg(s) === 1'b1)
            c++;
      end
   endtask
   task automatic hold_lo(input int s, input int k);
      int c;
      cnt(s, k, c);
      chk(16'(c), 16'h0);
   endtask
   task automatic flash(input int s, input int k);
      int c;
      cnt(s, k, c);
      chk(16'(c > 0 && c < k), 16'h1);
   endtask
   task automatic wt(input int s, input logic v, input int lim, output int k);
      k = 0;
      while (sg(s) !== v && k < lim) begin
         @(negedge clk_i);
         k++;
      end
      chk(16'(sg(s)), 16'(v));
   endtask
   initial begin
      rst_i = 1'b1;
      {range_500_i, band_mode_i, band_ok_i} = 3'h0;
      set_flags(1'b0, 1'b0, 1'b0);
      set_diag(1'b0, 10'h000, 1'b0, 10'h2A5);
      set_meas(10'h096, 8'h00, 16'h0000);
      cyc(16);
      rst_i = 1'b0;
      chk(16'(actual_out_o), 16'h0);
      fork
         hsc_plc_model_i.cal(45);
         hold_lo(0, 55);
         begin cyc(12); flash(4, 24); end
      join
      cyc(200);
      fork
         hsc_plc_model_i.cal(2);
         hold_lo(0, 20);
      join
      fork
         hsc_plc_model_i.cal(12);
         begin wt(0, 1'b1, 20, n); wt(0, 1'b0, 80, n); chk(16'(n), 16'(CAL_CYC)); end
         begin
            wt(0, 1'b1, 20, n);
            cyc(2);
            chk(16'(cal_ref_o), 16'h14);
            chk(16'(cal_led_o), 16'h1);
            chk(16'(actual_out_o), 16'h0);
            hsc_plc_model_i.drive(1'b1, 1'b0, 1'b0, 10'h200);
            hold_lo(1, 30);
         end
      join
      wt(1, 1'b1, 20, n);
      cyc(2);
      chk(16'(heat_led_o), 16'h1);
      chk(16'(cal_led_o), 16'h0);
      fork
         hsc_plc_model_i.cal(15);
         hold_lo(0, 30);
      join
      chk(16'(heat_led_o), 16'h1);
      hold_lo(7, 256);
      set_meas(10'h096, 8'h80, 16'h0000);
      cnt(7, 256, n);
      chk(16'(n), 16'h80);
      hsc_plc_model_i.drive(1'b0, 1'b0, 1'b0, 10'h200);
      wt(1, 1'b0, 20, n);
      hsc_plc_model_i.drive(1'b1, 1'b0, 1'b0, 10'h089);
      hold_lo(1, 30);
      flash(5, 40);
      hsc_plc_model_i.drive(1'b0, 1'b0, 1'b1, 10'h200);
      wt(3, 1'b1, 20, n);
      cyc(2);
      chk(16'(cp_led_o), 16'h1);
      hsc_plc_model_i.drive(1'b0, 1'b0, 1'b1, 10'h028);
      wt(3, 1'b0, 20, n);
      flash(6, 40);
      hsc_plc_model_i.drive(1'b0, 1'b0, 1'b0, 10'h200);
      set_meas(10'h08F, 8'h80, 16'h0000);
      cyc(3);
      chk(16'(temp_ok_led_o), 16'h1);
      set_meas(10'h08E, 8'h80, 16'h0000);
      cyc(3);
      chk(16'(temp_ok_led_o), 16'h0);
      {band_mode_i, band_ok_i} = 2'h3;
      cyc(3);
      chk(16'(temp_ok_led_o), 16'h1);
      {band_mode_i, band_ok_i} = 2'h0;
      set_meas(10'h096, 8'h80, 16'h0000);
      for (int i = 0; i < 2; i++) begin
         range_500_i = i[0];
         cyc(4);
         chk(16'(actual_out_o), i ? 16'h132 : 16'h1FF);
      end
      range_500_i = 1'b0;
      set_diag(1'b0, 10'h000, 1'b1, 10'h2A5);
      cyc(3);
      chk(16'(actual_out_o), 16'h2A5);
      set_diag(1'b0, 10'h000, 1'b0, 10'h2A5);
      hsc_plc_model_i.drive(1'b0, 1'b1, 1'b0, 10'h200);
      cyc(12);
      chk(16'(actual_out_o), 16'h0);
      fork
         hsc_plc_model_i.cal(12);
         hold_lo(0, 25);
      join
      hsc_plc_model_i.drive(1'b1, 1'b0, 1'b0, 10'h200);
      hold_lo(1, 36);
      wt(1, 1'b1, 40, n);
      hsc_plc_model_i.drive(1'b0, 1'b0, 1'b0, 10'h200);
      wt(1, 1'b0, 20, n);
      set_meas(10'h096, 8'h80, 16'h00C8);
      fork
         hsc_plc_model_i.cal(80);
         begin hold_lo(0, 30); set_meas(10'h096, 8'h80, 16'h0032); wt(0, 1'b1, 15, n); end
      join
      wt(0, 1'b0, 80, n);
      set_flags(1'b0, 1'b1, 1'b0);
      fork
         hsc_plc_model_i.cal(12);
         wt(2, 1'b1, 3 * CAL_CYC + 40, n);
      join
      chk(16'(n > 2 * CAL_CYC), 16'h1);
      chk(16'(cal_err_o), 16'h72);
      set_flags(1'b0, 1'b0, 1'b0);
      cyc(2);
      chk(16'(cal_busy_o), 16'h0);
      set_flags(1'b1, 1'b0, 1'b0);
      hsc_plc_model_i.drive(1'b0, 1'b0, 1'b0, 10'h08C);
      fork
         hsc_plc_model_i.cal(12);
         wt(2, 1'b1, 30, n);
      join
      chk(16'(cal_err_o), 16'h73);
      chk(16'(cal_busy_o), 16'h0);
      hsc_plc_model_i.drive(1'b0, 1'b0, 1'b0, 10'h066);
      fork
         hsc_plc_model_i.cal(12);
         begin
            wt(0, 1'b1, 30, n);
            chk(16'(cal_ref_o), 16'h1D);
            set_flags(1'b1, 1'b0, 1'b1);
            wt(2, 1'b1, 10, n);
         end
      join
      chk(16'(cal_err_o), 16'h74);
      set_flags(1'b0, 1'b0, 1'b0);
      wt(0, 1'b0, 80, n);
      set_diag(1'b1, 10'h0CA, 1'b0, 10'h2A5);
      fork
         hsc_plc_model_i.cal(15);
         hold_lo(0, 30);
      join
      set_diag(1'b1, 10'h066, 1'b0, 10'h2A5);
      fork
         hsc_plc_model_i.cal(12);
         wt(0, 1'b1, 30, n);
      join
      set_diag(1'b0, 10'h066, 1'b0, 10'h2A5);
      wt(0, 1'b0, 80, n);
      test_done;
   end
endmodule // test_heat_sealing_control_sequencer
